//--- src/pwp_guard_top.sv
// Peripheral write-protect bank with an AXI4-Lite register slave.
// Assumes one clock, synchronous active-low reset, and that the guarded
// peripherals present one-cycle write request pulses on guard_req.
//
// Notes on behaviour
// (R1) Byte, halfword, word accesses complete indivisibly.
// (R2) Each byte lane writes independently.
// (R3) Zero bits written change nothing.
// (R4) One to clear register drops protection.
// (R5) Bits: trace 6, port 3, nvm 2, service 1.
// (R6) Clear register at 0x00, reset 0x000002.
// (R7) Set register at 0x04, same reset.
// (R8) One to set register enables protection.
// (R9) Both registers read identical state.
// (R10) Protected peripheral write discarded, error signalled.
// (R11) Setting already protected bit raises error.
// (R12) Other bits read zero, writes ignored.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none

module pwp_guard_top
   import pwp_pkg::*;
(
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,

   // AXI4-Lite write address channel.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,

   // AXI4-Lite write data channel.
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [STRB_W-1:0] s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,

   // AXI4-Lite write response channel.
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,

   // AXI4-Lite read address channel.
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,

   // AXI4-Lite read data channel.
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,

   // Guarded peripheral writes: bit 0 service unit, 1 nvm, 2 port, 3 trace.
   input  wire logic [3:0]        guard_req,
   output logic      [3:0]        guard_grant,
   output logic                   guard_err,

   // Protection state and interrupt.
   output logic      [3:0]        prot_state,
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Types.

   typedef enum logic [1:0] {
      WS_IDLE    = 2'b00,
      WS_COLLECT = 2'b01,
      WS_RESP    = 2'b11
   } pwp_wstate_t;

   ////////////////////////////////////////////////////////////////////////////
   // Functions.

   // A byte or halfword access may carry the address of its own lane, so only
   // the word index picks the register and the strobes pick the lanes.
   function automatic logic same_word(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] ofs);
      return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   pwp_wstate_t       wstate_q;
   pwp_wstate_t       wstate_d;

   logic              aw_got_q;
   logic              w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [STRB_W-1:0] wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;

   logic              rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0]        rresp_q;

   logic [DATA_W-1:0] status_q;
   logic [DATA_W-1:0] mask_q;
   logic              guard_err_q;

   logic              aw_hs;
   logic              w_hs;
   logic              b_hs;
   logic              ar_hs;
   logic              r_hs;
   logic              commit;

   logic              hit_clear;
   logic              hit_set;
   logic              hit_status;
   logic              hit_mask;
   logic              hit_any;

   logic              rd_clear;
   logic              rd_set;
   logic              rd_status;
   logic              rd_mask;
   logic              rd_any;
   logic [DATA_W-1:0] rd_word;

   logic [DATA_W-1:0] prot_word;
   logic              double_hit;
   logic [3:0]        prot_slots;
   logic              access_hit;
   logic [DATA_W-1:0] wmask;
   logic [DATA_W-1:0] status_clr;
   logic [DATA_W-1:0] status_set;
   logic [DATA_W-1:0] status_d;
   logic [DATA_W-1:0] mask_d;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel handshakes.

   // A second write is not taken until the response of the first has gone.
   assign s_axi_awready = (wstate_q != WS_RESP) & ~aw_got_q;
   assign s_axi_wready  = (wstate_q != WS_RESP) & ~w_got_q;

   assign aw_hs  = s_axi_awvalid & s_axi_awready;
   assign w_hs   = s_axi_wvalid & s_axi_wready;
   assign b_hs   = bvalid_q & s_axi_bready;
   assign commit = aw_got_q & w_got_q & (wstate_q != WS_RESP); // R1

   always_comb begin
      wstate_d = wstate_q;
      case (wstate_q)
         WS_IDLE: begin
            if (aw_hs || w_hs) begin
               wstate_d = WS_COLLECT;
            end
         end
         WS_COLLECT: begin
            if (commit) begin
               wstate_d = WS_RESP;
            end
         end
         WS_RESP: begin
            if (b_hs) begin
               wstate_d = WS_IDLE;
            end
         end
         default: begin
            wstate_d = WS_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate_q <= WS_IDLE;
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else begin
         wstate_q <= wstate_d;
         if (aw_hs) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (commit) begin
            aw_got_q <= 1'b0;
         end
         if (w_hs) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (commit) begin
            w_got_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write decode.

   assign hit_clear  = same_word(awaddr_q, OFS_PROT_CLEAR); // R2 R6
   assign hit_set    = same_word(awaddr_q, OFS_PROT_SET); // R2 R7
   assign hit_status = same_word(awaddr_q, OFS_IRQ_STATUS);
   assign hit_mask   = same_word(awaddr_q, OFS_IRQ_MASK);
   // With the present address width every word is mapped; the error path
   // only matters if the map grows without new registers behind it.
   assign hit_any    = hit_clear | hit_set | hit_status | hit_mask;

   assign wmask = lane_mask(wstrb_q); // R2

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (commit) begin
         bvalid_q <= 1'b1;
         if (!hit_any || double_hit) begin
            bresp_q <= RESP_SLVERR; // R11
         end else begin
            bresp_q <= RESP_OKAY;
         end
      end else if (b_hs) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Protection state.

   pwp_prot_bank u_bank (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .wr_en      (commit & (hit_clear | hit_set)),
      .wr_is_set  (hit_set),
      .wr_data    (wdata_q),
      .wr_strb    (wstrb_q),
      .prot       (prot_word),
      .double_hit (double_hit)
   );

   assign prot_slots = {prot_word[BIT_TRACE_BUFFER_UNIT],
                        prot_word[BIT_PORT],
                        prot_word[BIT_NONVOLATILE_MEM],
                        prot_word[BIT_DEVICE_SERVICE]}; // R5

   assign prot_state = prot_slots;

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral write guard.

   // Grants are combinational so the peripheral can drop the write in the
   // same cycle; the error pulse is registered and follows one cycle later.
   assign guard_grant = guard_req & ~prot_slots; // R10
   assign access_hit  = |(guard_req & prot_slots); // R10

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_err_q <= 1'b0;
      end else begin
         guard_err_q <= access_hit; // R10
      end
   end

   assign guard_err = guard_err_q;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask.

   assign status_clr = (commit & hit_status) ? (wdata_q & wmask) : '0;

   always_comb begin
      status_set = '0;
      status_set[IRQ_BIT_ACCESS] = access_hit;
      status_set[IRQ_BIT_DOUBLE] = commit & double_hit;
   end

   // A new event in the cycle of its clear keeps the bit set.
   assign status_d = ((status_q & ~status_clr) | status_set) & IRQ_VALID;

   assign mask_d = (commit & hit_mask)
                   ? (((mask_q & ~wmask) | (wdata_q & wmask)) & IRQ_VALID)
                   : mask_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= IRQ_RESET;
         mask_q   <= MASK_RESET;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
      end
   end

   assign irq = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Read channel.

   assign s_axi_arready = ~rvalid_q;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign r_hs  = rvalid_q & s_axi_rready;

   // Reads decode the word index exactly as writes do, so a byte read of any
   // lane lands on the register that holds it.
   assign rd_clear  = same_word(s_axi_araddr, OFS_PROT_CLEAR); // R2
   assign rd_set    = same_word(s_axi_araddr, OFS_PROT_SET); // R2
   assign rd_status = same_word(s_axi_araddr, OFS_IRQ_STATUS);
   assign rd_mask   = same_word(s_axi_araddr, OFS_IRQ_MASK);
   assign rd_any    = rd_clear | rd_set | rd_status | rd_mask;

   // Full words are returned; the master picks the lanes it wants.
   assign rd_word = ((rd_clear | rd_set) ? prot_word : '0)  // R9 R12
                  | (rd_status ? status_q : '0)
                  | (rd_mask ? mask_q : '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word; // R1
         rresp_q  <= rd_any ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule

`default_nettype wire

//--- src/pwp_pkg.sv
// Package for the peripheral write-protect bank.
// Holds register offsets, bit positions, reset values and shared helpers.
// Assumes a 32-bit AXI4-Lite register bus with byte strobes.
`default_nettype none

package pwp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry.

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.

   localparam logic [ADDR_W-1:0] OFS_PROT_CLEAR = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PROT_SET   = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'hC;

   ////////////////////////////////////////////////////////////////////////////
   // Protection bit positions and reset values.

   localparam int unsigned BIT_TRACE_BUFFER_UNIT = 6;
   localparam int unsigned BIT_PORT              = 3;
   localparam int unsigned BIT_NONVOLATILE_MEM   = 2;
   localparam int unsigned BIT_DEVICE_SERVICE    = 1;

   localparam logic [DATA_W-1:0] PROT_RESET = 32'h0000_0002;
   localparam logic [DATA_W-1:0] PROT_VALID = 32'h0000_004E;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status layout.

   localparam int unsigned IRQ_BIT_ACCESS = 0;
   localparam int unsigned IRQ_BIT_DOUBLE = 1;

   localparam logic [DATA_W-1:0] IRQ_VALID   = 32'h0000_0003;
   localparam logic [DATA_W-1:0] IRQ_RESET   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] MASK_RESET  = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // AXI response codes.

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Expands byte strobes into a bit mask over the data word.
   function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < STRB_W; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

endpackage

`default_nettype wire

//--- src/pwp_prot_bank.sv
// Shared protection state behind the set and clear registers.
// Assumes the caller qualifies each write with one strobe and byte lanes.
`default_nettype none

module pwp_prot_bank
   import pwp_pkg::*;
(
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write port.
   input  wire logic              wr_en,
   input  wire logic              wr_is_set,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic [STRB_W-1:0] wr_strb,
   // State.
   output logic      [DATA_W-1:0] prot,
   output logic                   double_hit
);

   logic [DATA_W-1:0] prot_q;
   logic [DATA_W-1:0] prot_d;
   logic [DATA_W-1:0] ones;

   // Only ones in enabled lanes on implemented bits take effect.
   assign ones = wr_data & lane_mask(wr_strb) & PROT_VALID; // R2 R3 R12

   // Setting a bit that is already protected is flagged.
   assign double_hit = wr_en & wr_is_set & (|(ones & prot_q)); // R11

   always_comb begin
      prot_d = prot_q;
      if (wr_en && wr_is_set) begin
         prot_d = prot_q | ones; // R8
      end else if (wr_en) begin
         prot_d = prot_q & ~ones; // R4
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_q <= PROT_RESET; // R6 R7
      end else begin
         prot_q <= prot_d; // R1
      end
   end

   assign prot = prot_q & PROT_VALID; // R9 R12

endmodule

`default_nettype wire

//--- testbench/pwp_guard_monitor.sv
// Port checker for the peripheral write-protect bank.
// Assumes one clock domain and a synchronous active-low reset.
`default_nettype none

module pwp_guard_monitor
   import pwp_pkg::*;
(
   // Clock and reset.
   input wire logic              aclk,
   input wire logic              aresetn,
   // Register bus.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [STRB_W-1:0] s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   // Guard side.
   input wire logic [3:0]        guard_req,
   input wire logic [3:0]        guard_grant,
   input wire logic              guard_err,
   input wire logic [3:0]        prot_state
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Protection bits placed where the registers show them.
   wire [7:0] prot_pos = {1'b0, prot_state[3], 2'b00, prot_state[2:0], 1'b0};

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence set_dup;
      wr_taken ##0 (s_axi_awaddr == OFS_PROT_SET && s_axi_wstrb[0]
                    && |(s_axi_wdata[7:0] & prot_pos));
   endsequence

   AST_RESET_VAL: assert property ($rose(aresetn) |-> prot_state == 4'h1 && !s_axi_bvalid)
      else $error("protection state wrong after reset");
   AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write answer not on time");
   AST_DUP_SET: assert property (set_dup |-> ##2 s_axi_bresp == RESP_SLVERR)
      else $error("double set not refused");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer not on time");
   AST_GRANT: assert property (guard_grant == (guard_req & ~prot_state))
      else $error("grant ignores protection");
   AST_ERR: assert property (|(guard_req & prot_state) |=> guard_err)
      else $error("missing access error");
   AST_NO_ERR: assert property (!(|(guard_req & prot_state)) |=> !guard_err)
      else $error("spurious access error");
   AST_STATE_MOVE: assert property (!$stable(prot_state) |-> $rose(s_axi_bvalid))
      else $error("protection changed without a write");
endmodule

bind pwp_guard_top pwp_guard_monitor i_pwp_guard_monitor (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .guard_req, .guard_grant, .guard_err, .prot_state
);

`default_nettype wire

//--- testbench/pwp_periph_model.sv
// Model of the guarded peripherals that issue write requests.
// Assumes the bench names the requesters to fire with a one-cycle command.
`default_nettype none

module pwp_periph_model (
   // Clock.
   input  wire logic       aclk,
   // Command from the bench and the guard's answer.
   input  wire logic [3:0] fire,
   input  wire logic [3:0] guard_grant,
   output logic      [3:0] guard_req,
   output logic      [3:0] landed_q
);
   timeunit 1ns;
   timeprecision 1ns;

   // A refused write is not retried; the bench sees what got through.
   always_ff @(posedge aclk) begin
      guard_req <= fire;
      landed_q  <= guard_req & guard_grant;
   end
endmodule

`default_nettype wire

//--- testbench/test_pwp_guard_top.sv
// Self-checking bench for the write-protect bank over AXI4-Lite.
// Assumes the monitor is bound in and the peripheral model drives guard_req.
`default_nettype none

module test_pwp_guard_top
   import pwp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic              aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
   logic              s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0] s_axi_wdata = '0, st, s_axi_rdata;
   logic [STRB_W-1:0] s_axi_wstrb = '0;
   logic [3:0]        fire = '0, guard_req, guard_grant, prot_state, landed;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic              s_axi_rvalid, guard_err, irq;
   int                error_cnt = 0, checks = 0, cyc = 0;
   int                pos [3] = '{BIT_TRACE_BUFFER_UNIT, BIT_PORT, BIT_NONVOLATILE_MEM};

   pwp_guard_top i_pwp_guard_top (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .guard_req, .guard_grant, .guard_err, .prot_state, .irq
   );
   pwp_periph_model i_pwp_periph_model (
      .aclk, .fire, .guard_grant, .guard_req, .landed_q(landed)
   );

   always #25 aclk = ~aclk;

   // The run needs about 115 cycles; a hang is cut well beyond that.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bits(input logic [3:0] got, input logic [3:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cmp_bits({2'b00, s_axi_bresp}, {2'b00, er}, "bresp");
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      cmp_word(s_axi_rdata, exp, "rdata");
      cmp_bits({2'b00, s_axi_rresp}, {2'b00, RESP_OKAY}, "rresp");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_PROT_CLEAR, PROT_RESET);
      rd(OFS_PROT_SET, PROT_RESET);
      cmp_bits(prot_state, 4'h1, "state");
      $display("test reset done");
      st = PROT_RESET;
      foreach (pos[i]) begin
         wr(OFS_PROT_SET, 32'h0000_0001 << pos[i], 4'hF, RESP_OKAY);
         st = st | (32'h0000_0001 << pos[i]);
         rd(OFS_PROT_CLEAR, st);
         rd(OFS_PROT_SET, st);
      end
      wr(OFS_PROT_SET, 32'h0000_0002, 4'hF, RESP_SLVERR);
      cmp_bits(prot_state, 4'hF, "state");
      $display("test set done");
      wr(OFS_PROT_CLEAR, 32'hFFFF_FFB1, 4'hF, RESP_OKAY);
      rd(OFS_PROT_SET, 32'h0000_004E);
      wr(OFS_PROT_CLEAR, 32'h0000_000A, 4'hE, RESP_OKAY);
      rd(OFS_PROT_CLEAR, 32'h0000_004E);
      wr(OFS_PROT_CLEAR, 32'h0000_000A, 4'h1, RESP_OKAY);
      rd(OFS_PROT_CLEAR, 32'h0000_0044);
      wr(OFS_PROT_CLEAR, 32'h0000_0040, 4'h3, RESP_OKAY);
      rd(OFS_PROT_SET, 32'h0000_0004);
      wr(OFS_PROT_CLEAR | 4'h2, 32'h0000_0000, 4'h4, RESP_OKAY);
      rd(OFS_PROT_SET | 4'h3, 32'h0000_0004);
      cmp_bits(prot_state, 4'h2, "state");
      $display("test clear done");
      @(posedge aclk);
      fire <= 4'hF;
      @(posedge aclk);
      fire <= 4'h0;
      @(negedge aclk);
      cmp_bits(guard_grant, 4'hD, "grant");
      @(negedge aclk);
      cmp_bits({3'b000, guard_err}, 4'h1, "error");
      cmp_bits(landed, 4'hD, "landed");
      rd(OFS_IRQ_STATUS, 32'h0000_0003);
      cmp_bits({3'b000, irq}, 4'h0, "irq");
      wr(OFS_IRQ_MASK, 32'h0000_0001, 4'hF, RESP_OKAY);
      cmp_bits({3'b000, irq}, 4'h1, "irq");
      wr(OFS_IRQ_STATUS, 32'h0000_0001, 4'hF, RESP_OKAY);
      cmp_bits({3'b000, irq}, 4'h0, "irq");
      rd(OFS_IRQ_STATUS, 32'h0000_0002);
      $display("test guard done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_PROT_SET, PROT_RESET);
      $display("test rerun done");
      end_sim();
   end
endmodule

`default_nettype wire
